// ==== wguard.sv ====
// Write guard, address matcher and configuration bytes of the bus slave.
// Functional notes
// - Apply the stricter of lock register and protect pin.
// - Top lock level: only lock, page, unlock and store-all writes pass.
// - Middle level adds peak clear, operation, clear faults, status clears.
// - Lowest nonzero level adds on/off config and output voltage command.
// - Lock value zero lets every write pass, pin permitting.
// - Pin high: only page, operation, peaks, unlock, clear faults, status.
// - Device address byte gives the seven-bit slave address when the select pin is open.
// - Writing 0x80 to an address register disables that address.
// - Global addresses 0x5a and 0x5b always match.
// - Channel address low bit comes from the select pin unless the pin is open.
// - Select pin open: use stored device address value.
// - Alert response returns channel address unless it is 0x80.
// - Host writes and reads back rail address; read mismatch flags a fault.
// - Channel bit 4 set: no run low pulse on command off.
// - Channel bit 3: on during turn-off forces off, 120 ms off.
// - Channel bit 2: output held off while sync clock is low.
// - Channel bit 1: general pin low does not raise alert.
// - Channel bit 0 clear: retry waits for output decay.
// - Shared bit 6 set: resistor configuration pins ignored.
// - Shared bit 2: writes need valid check byte; bad ones fault.
// - Shared bit 1 permits clock stretching.
// - Shared bit 0: run pin rising edge acts as clear faults.
// - Stretch only when enabled and bus above 100 kHz.
`timescale 1ns/1ps
module wguard
  import wguard_pkg::*;
#(
  parameter int MIN_OFF_CYCLES = MIN_OFF_CYC
)(
  // Clock and reset.
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  // Decoded command writes from the bus front end.
  input  wire logic       cmd_valid_in,
  input  wire logic [7:0] cmd_code_in,
  input  wire logic [7:0] cmd_data_in,
  input  wire logic       cmd_pec_present_in,
  input  wire logic       cmd_pec_ok_in,
  output logic            cmd_accept_out,
  output logic            cmd_reject_out,
  // Command reads.
  input  wire logic       rd_req_in,
  input  wire logic [7:0] rd_code_in,
  output logic            rd_valid_out,
  output logic [7:0]      rd_data_out,
  // Address matching.
  input  wire logic       addr_valid_in,
  input  wire logic [6:0] addr_in,
  input  wire logic       bus_fast_in,
  output logic            addr_hit_out,
  output logic            addr_global_out,
  output logic [1:0]      addr_chan_out,
  output logic            clock_stretch_out,
  // Rail read contention check.
  input  wire logic       rail_rd_done_in,
  input  wire logic [7:0] rail_drove_in,
  input  wire logic [7:0] rail_seen_in,
  // Pins from outside the clock domain.
  input  wire logic       write_protect_pin_in,
  input  wire logic       address_select_pin_in,
  input  wire logic       address_select_open_in,
  input  wire logic [6:0] resistor_config_in,
  input  wire logic [1:0] run_pin_in,
  input  wire logic       shared_sync_clock_in,
  input  wire logic [1:0] gpio_low_in,
  // Channel control from the sequencer.
  input  wire logic [1:0] off_cmd_in,
  input  wire logic [1:0] on_cmd_in,
  input  wire logic [1:0] turn_off_busy_in,
  input  wire logic [1:0] below_decay_in,
  input  wire logic [1:0] alert_chan_in,
  // Results.
  output logic            communication_fault_out,
  output logic            clear_faults_out,
  output logic [1:0]      run_low_pulse_out,
  output logic [1:0]      force_off_out,
  output logic [1:0]      on_permit_out,
  output logic [1:0]      chan_enable_out,
  output logic [1:0]      retry_permit_out,
  output logic            gpio_alert_out,
  output logic [6:0]      ara_address_out
);

  if (MIN_OFF_CYCLES < 1 || MIN_OFF_CYCLES >= (1 << TMR_W))
    $error("MIN_OFF_CYCLES does not fit the off timer");

  typedef struct packed {
    logic [PIN_W-1:0]       pin1;
    logic [PIN_W-1:0]       pin2;
    logic [1:0]             run_prev;
    logic [7:0]             page;
    logic [7:0]             lock;
    logic [7:0]             dev_addr;
    logic [7:0]             shared;
    logic [1:0][7:0]        chan_cfg;
    logic [1:0][7:0]        chan_addr;
    logic [1:0][7:0]        rail_addr;
    logic [1:0][TMR_W-1:0]  off_tmr;
    logic                   accept;
    logic                   reject;
    logic                   fault;
    logic                   clr;
    logic                   rd_valid;
    logic [7:0]             rd_data;
    logic                   hit;
    logic                   global;
    logic [1:0]             hit_chan;
    logic [1:0]             run_low;
    logic [1:0]             force_off;
    logic [6:0]             ara;
  } state_t;

  localparam state_t RST = '{
    pin1: '0, pin2: '0, run_prev: 2'h0, page: RST_PAGE,
    lock: RST_WRITE_LOCK, dev_addr: RST_DEV_ADDR, shared: RST_SHARED_CFG,
    chan_cfg: {RST_CHAN_CFG, RST_CHAN_CFG},
    chan_addr: {RST_CHAN_ADDR, RST_CHAN_ADDR},
    rail_addr: {RST_RAIL_ADDR, RST_RAIL_ADDR},
    off_tmr: '0, accept: 1'b0, reject: 1'b0, fault: 1'b0, clr: 1'b0,
    rd_valid: 1'b0, rd_data: 8'h00, hit: 1'b0, global: 1'b0,
    hit_chan: 2'h0, run_low: 2'h0, force_off: 2'h0, ara: 7'h00};

  state_t cur;
  state_t nxt;

  // Synchronised pin levels; only the second stage is ever read.
  logic             wp_pin;
  logic             address_select_pin;
  logic             address_select_pin_open;
  logic [1:0]       run_lvl;
  logic             sync_lvl;
  logic [1:0]       gpio_low;
  logic [6:0]       rcfg;
  logic [PIN_W-1:0] pins_raw;

  assign pins_raw  = {resistor_config_in, gpio_low_in, shared_sync_clock_in,
                      run_pin_in, address_select_open_in,
                      address_select_pin_in, write_protect_pin_in};
  assign wp_pin    = cur.pin2[PIN_WP];
  assign address_select_pin      = cur.pin2[PIN_ADDRESS_SELECT_PIN];
  assign address_select_pin_open = cur.pin2[PIN_AOPEN];
  assign run_lvl   = cur.pin2[PIN_RUN +: 2];
  assign sync_lvl  = cur.pin2[PIN_SYNC];
  assign gpio_low  = cur.pin2[PIN_GPIO +: 2];
  assign rcfg      = cur.pin2[PIN_RCFG +: 7];

  // Status clears are allowed wherever fault clearing is allowed.
  function automatic logic is_status(input logic [7:0] c);
    return (c >= CMD_STATUS_LO) && (c <= CMD_STATUS_HI);
  endfunction

  // Lock register filter; the levels nest, each adding to the stricter.
  function automatic logic lock_ok(input logic [7:0] lvl,
                                   input logic [7:0] c);
    logic top;
    logic mid;
    logic low;
    top = (c == CMD_WRITE_LOCK) || (c == CMD_PAGE) ||
          (c == CMD_NVM_UNLOCK) || (c == CMD_STORE_ALL);
    mid = top || (c == CMD_CLR_PEAKS) || (c == CMD_OPERATION) ||
          (c == CMD_CLEAR_FLT) || is_status(c);
    low = mid || (c == CMD_ON_OFF_CFG) || (c == CMD_VOUT_CMD);
    if (lvl[LOCK_TOP])      return top;
    else if (lvl[LOCK_MID]) return mid;
    else if (lvl[LOCK_LOW]) return low;
    else                    return 1'b1;
  endfunction

  // Protect pin filter.
  function automatic logic pin_ok(input logic [7:0] c);
    return (c == CMD_PAGE) || (c == CMD_OPERATION) ||
           (c == CMD_CLR_PEAKS) || (c == CMD_NVM_UNLOCK) ||
           (c == CMD_CLEAR_FLT) || is_status(c);
  endfunction

  // Effective addresses after strap and select pin handling.
  logic [6:0]      dev_eff;
  logic [1:0][6:0] chan_eff;
  logic [1:0]      chan_sel;

  always_comb
  begin
    if (address_select_pin_open)
      dev_eff = cur.dev_addr[6:0];
    else if (cur.shared[SH_IGNORE_RCFG])
      dev_eff = {cur.dev_addr[6:1], address_select_pin};
    else
      dev_eff = {rcfg[6:1], address_select_pin};
    for (int i = 0; i < 2; i++)
      chan_eff[i] = address_select_pin_open ? cur.chan_addr[i][6:0]
                              : {cur.chan_addr[i][6:1], address_select_pin};
    if (cur.page == PAGE_ALL)
      chan_sel = 2'b11;
    else if (cur.page == 8'h01)
      chan_sel = 2'b10;
    else if (cur.page == 8'h00)
      chan_sel = 2'b01;
    else
      chan_sel = 2'b00;
  end

  // Next-state logic; pulses other than clear faults default low and registers hold.
  always_comb
  begin
    logic       allow;
    logic       pec_bad;
    logic [1:0] rise;
    nxt           = cur;
    allow         = 1'b0;
    pec_bad       = 1'b0;
    rise          = run_lvl & ~cur.run_prev;
    nxt.pin1      = pins_raw;
    nxt.pin2      = cur.pin1;
    nxt.run_prev  = run_lvl;
    nxt.accept    = 1'b0;
    nxt.reject    = 1'b0;
    nxt.fault     = 1'b0;
    nxt.rd_valid  = 1'b0;
    nxt.hit       = 1'b0;
    nxt.global    = 1'b0;
    nxt.hit_chan  = 2'h0;
    nxt.run_low   = 2'h0;
    nxt.force_off = 2'h0;
    nxt.clr       = cur.shared[SH_RUN_CLEAR] && (rise != 2'h0);
    if (cmd_valid_in)
    begin
      pec_bad = cmd_pec_present_in ? !cmd_pec_ok_in
                                   : cur.shared[SH_PEC_REQ];
      // Intersection of both filters is the stricter of the two.
      allow = !pec_bad && lock_ok(cur.lock, cmd_code_in) &&
              (!wp_pin || pin_ok(cmd_code_in));
      nxt.accept = allow;
      nxt.reject = !allow;
      nxt.fault  = pec_bad;
      if (allow)
      begin
        case (cmd_code_in)
          CMD_PAGE:       nxt.page     = cmd_data_in;
          CMD_WRITE_LOCK: nxt.lock     = cmd_data_in;
          CMD_DEV_ADDR:   nxt.dev_addr = cmd_data_in;
          CMD_SHARED_CFG: nxt.shared   = cmd_data_in;
          CMD_CLEAR_FLT:  nxt.clr      = 1'b1;
          default:        nxt.page     = cur.page;
        endcase
        for (int i = 0; i < 2; i++)
          if (chan_sel[i])
          begin
            if (cmd_code_in == CMD_CHAN_CFG)
              nxt.chan_cfg[i] = cmd_data_in;
            if (cmd_code_in == CMD_CHAN_ADDR)
              nxt.chan_addr[i] = cmd_data_in;
            if (cmd_code_in == CMD_RAIL_ADDR)
              nxt.rail_addr[i] = cmd_data_in;
          end
      end
    end
    // A driven rail value that reads back differently is contention.
    if (rail_rd_done_in && (rail_drove_in != rail_seen_in))
      nxt.fault = 1'b1;
    // Register reads answer one cycle after the request.
    if (rd_req_in)
    begin
      nxt.rd_valid = 1'b1;
      case (rd_code_in)
        CMD_PAGE:       nxt.rd_data = cur.page;
        CMD_WRITE_LOCK: nxt.rd_data = cur.lock;
        CMD_DEV_ADDR:   nxt.rd_data = cur.dev_addr;
        CMD_SHARED_CFG: nxt.rd_data = cur.shared;
        CMD_CHAN_CFG:   nxt.rd_data = cur.chan_cfg[chan_sel == 2'b10];
        CMD_CHAN_ADDR:  nxt.rd_data = cur.chan_addr[chan_sel == 2'b10];
        CMD_RAIL_ADDR:  nxt.rd_data = cur.rail_addr[chan_sel == 2'b10];
        default:        nxt.rd_data = RD_UNMAPPED;
      endcase
    end
    // Address compare; a register holding 0x80 is excluded before its low seven bits are compared.
    if (addr_valid_in)
    begin
      nxt.global = (addr_in == GLOBAL_ADDR_A) ||
                   (addr_in == GLOBAL_ADDR_B);
      nxt.hit    = nxt.global ||
                   ((cur.dev_addr != ADDR_OFF) && (addr_in == dev_eff));
      for (int i = 0; i < 2; i++)
        nxt.hit_chan[i] =
          ((cur.chan_addr[i] != ADDR_OFF) && (addr_in == chan_eff[i])) ||
          ((cur.rail_addr[i] != ADDR_OFF) &&
           (addr_in == cur.rail_addr[i][6:0]));
      nxt.hit = nxt.hit || (nxt.hit_chan != 2'h0);
    end
    // Alert response address follows the first alerting channel.
    nxt.ara = dev_eff;
    for (int i = 1; i >= 0; i--)
      if (alert_chan_in[i] && (cur.chan_addr[i] != ADDR_OFF))
        nxt.ara = chan_eff[i];
    // Per-channel power-off behaviour.
    for (int i = 0; i < 2; i++)
    begin
      nxt.run_low[i] = off_cmd_in[i] &&
                       !cur.chan_cfg[i][CH_NO_RUN_LOW];
      if (cur.off_tmr[i] != '0)
        nxt.off_tmr[i] = cur.off_tmr[i] - 1'b1;
      if (on_cmd_in[i] && turn_off_busy_in[i] &&
          cur.chan_cfg[i][CH_SHORT_CYCLE])
      begin
        nxt.force_off[i] = 1'b1;
        nxt.off_tmr[i]   = TMR_W'(MIN_OFF_CYCLES);
      end
    end
  end

  // Single state register; reset loads constants only.
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cur <= RST;
    else
      cur <= nxt;
  end

  // Outputs.
  assign cmd_accept_out          = cur.accept;
  assign cmd_reject_out          = cur.reject;
  assign communication_fault_out = cur.fault;
  assign clear_faults_out        = cur.clr;
  assign rd_valid_out            = cur.rd_valid;
  assign rd_data_out             = cur.rd_data;
  assign addr_hit_out            = cur.hit;
  assign addr_global_out         = cur.global;
  assign addr_chan_out           = cur.hit_chan;
  assign run_low_pulse_out       = cur.run_low;
  assign force_off_out           = cur.force_off;
  assign ara_address_out         = cur.ara;
  // Stretching below 100 kHz only costs the host time, so it is withheld.
  assign clock_stretch_out = cur.shared[SH_STRETCH] && bus_fast_in;

  // Channel gating levels.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      on_permit_out[i]    = (cur.off_tmr[i] == '0) && !cur.force_off[i];
      chan_enable_out[i]  = !(cur.chan_cfg[i][CH_SYNC_HOLD] && !sync_lvl);
      retry_permit_out[i] = cur.chan_cfg[i][CH_NO_DECAY] ||
                            below_decay_in[i];
    end
    gpio_alert_out = |(gpio_low & ~{cur.chan_cfg[1][CH_NO_GPIO_ALR],
                                    cur.chan_cfg[0][CH_NO_GPIO_ALR]});
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  pin_block_a: assert property (cmd_valid_in && wp_pin && cur.lock == 8'h00
    && cmd_code_in == CMD_VOUT_CMD |=> cmd_reject_out && !cmd_accept_out)
    else $error("Write passed while protect pin high.");
  top_lock_a: assert property (cmd_valid_in && cur.lock[LOCK_TOP]
    && cmd_code_in == CMD_OPERATION |=> cmd_reject_out)
    else $error("Top lock level let a write pass.");
  low_lock_a: assert property (cmd_valid_in && !wp_pin && cur.lock == 8'h20
    && !cur.shared[SH_PEC_REQ] && !cmd_pec_present_in
    && cmd_code_in == CMD_VOUT_CMD |=> cmd_accept_out)
    else $error("Lowest lock level refused an allowed write.");
  global_hit_a: assert property (addr_valid_in && addr_in == GLOBAL_ADDR_B
    |=> addr_hit_out && addr_global_out)
    else $error("Global address not matched.");
  bad_pec_a: assert property (cmd_valid_in && cmd_pec_present_in
    && !cmd_pec_ok_in |=> communication_fault_out && !cmd_accept_out)
    else $error("Bad check byte not discarded.");
  lock_kept_a: assert property (cmd_reject_out |-> $stable(cur.lock)
    && $stable(cur.shared) && $stable(cur.dev_addr))
    else $error("Blocked write changed a register.");
  min_off_a: assert property ($rose(force_off_out[0])
    |-> !on_permit_out[0] [*8])
    else $error("On permitted inside minimum off time.");
  sync_hold_a: assert property (cur.chan_cfg[1][CH_SYNC_HOLD] && !sync_lvl
    |-> !chan_enable_out[1])
    else $error("Channel enabled with sync clock low.");
  run_clear_a: assert property (cur.shared[SH_RUN_CLEAR]
    && $rose(run_lvl[1]) |=> clear_faults_out)
    else $error("Run rising edge did not clear faults.");
  stretch_gate_a: assert property (!bus_fast_in |-> !clock_stretch_out)
    else $error("Stretch enabled on slow bus.");
  rail_fault_a: assert property (rail_rd_done_in
    && rail_drove_in != rail_seen_in |=> communication_fault_out)
    else $error("Rail contention not flagged.");

endmodule // wguard

// ==== wguard_pkg.sv ====
// Package with command codes, reset values and timing for the write guard.
package wguard_pkg;
  // Command codes that the guard stores or classifies.
  localparam logic [7:0] CMD_PAGE        = 8'h00;
  localparam logic [7:0] CMD_OPERATION   = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CFG  = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FLT   = 8'h03;
  localparam logic [7:0] CMD_WRITE_LOCK  = 8'h10;
  localparam logic [7:0] CMD_STORE_ALL   = 8'h15;
  localparam logic [7:0] CMD_VOUT_CMD    = 8'h21;
  localparam logic [7:0] CMD_STATUS_LO   = 8'h78;
  localparam logic [7:0] CMD_STATUS_HI   = 8'h80;
  localparam logic [7:0] CMD_NVM_UNLOCK  = 8'hbd;
  localparam logic [7:0] CMD_CLR_PEAKS   = 8'he3;
  localparam logic [7:0] CMD_CHAN_CFG    = 8'hd0;
  localparam logic [7:0] CMD_SHARED_CFG  = 8'hd1;
  localparam logic [7:0] CMD_CHAN_ADDR   = 8'hd8;
  localparam logic [7:0] CMD_DEV_ADDR    = 8'he6;
  localparam logic [7:0] CMD_RAIL_ADDR   = 8'hfa;
  // Values after reset.
  localparam logic [7:0] RST_PAGE        = 8'h00;
  localparam logic [7:0] RST_WRITE_LOCK  = 8'h00;
  localparam logic [7:0] RST_DEV_ADDR    = 8'h4f;
  localparam logic [7:0] RST_CHAN_ADDR   = 8'h80;
  localparam logic [7:0] RST_RAIL_ADDR   = 8'h80;
  localparam logic [7:0] RST_CHAN_CFG    = 8'h1f;
  localparam logic [7:0] RST_SHARED_CFG  = 8'h09;
  // Special values.
  localparam logic [7:0] ADDR_OFF        = 8'h80;
  localparam logic [7:0] PAGE_ALL        = 8'hff;
  localparam logic [6:0] GLOBAL_ADDR_A   = 7'h5a;
  localparam logic [6:0] GLOBAL_ADDR_B   = 7'h5b;
  localparam logic [7:0] RD_UNMAPPED     = 8'hff;
  // Write lock level bits, strictest first.
  localparam int LOCK_TOP = 7;
  localparam int LOCK_MID = 6;
  localparam int LOCK_LOW = 5;
  // Per-channel configuration bit positions.
  localparam int CH_NO_RUN_LOW  = 4;
  localparam int CH_SHORT_CYCLE = 3;
  localparam int CH_SYNC_HOLD   = 2;
  localparam int CH_NO_GPIO_ALR = 1;
  localparam int CH_NO_DECAY    = 0;
  // Shared configuration bit positions.
  localparam int SH_IGNORE_RCFG = 6;
  localparam int SH_PEC_REQ     = 2;
  localparam int SH_STRETCH     = 1;
  localparam int SH_RUN_CLEAR   = 0;
  // Synchronised pin vector layout.
  localparam int PIN_WP    = 0;
  localparam int PIN_ADDRESS_SELECT_PIN  = 1;
  localparam int PIN_AOPEN = 2;
  localparam int PIN_RUN   = 3;
  localparam int PIN_SYNC  = 5;
  localparam int PIN_GPIO  = 6;
  localparam int PIN_RCFG  = 8;
  localparam int PIN_W     = 15;
  // Timing.
  localparam int CLK_HZ      = 25_000_000;
  localparam int MIN_OFF_MS  = 120;
  localparam int MIN_OFF_CYC = MIN_OFF_MS * (CLK_HZ / 1000);
  localparam int TMR_W       = 22;
endpackage

// ==== bus_host.sv ====
// Bus host model that issues command writes, reads and address probes.
`timescale 1ns/1ps
module bus_host (
  // Clock.
  input  wire logic       clock_in,
  // Command writes and their answer.
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_code_out,
  output logic [7:0]      cmd_data_out,
  output logic            pec_present_out,
  output logic            pec_ok_out,
  input  wire logic       accept_in,
  input  wire logic       reject_in,
  input  wire logic       fault_in,
  // Reads and address probes.
  output logic            rd_req_out,
  output logic [7:0]      rd_code_out,
  input  wire logic [7:0] rd_data_in,
  output logic            addr_valid_out,
  output logic [6:0]      addr_out,
  input  wire logic       hit_in
);
  // All requests idle at time zero.
  initial
  begin
    {cmd_valid_out, rd_req_out, addr_valid_out} = 3'h0;
    {cmd_code_out, cmd_data_out, rd_code_out} = 24'h0;
    {pec_present_out, pec_ok_out, addr_out} = 9'h0;
  end

  // One write; released lines show inverted values so stale data is seen.
  // The host sends the check byte flags with every write.
  // Rail address is written and also read back by this host, as in the reset check.
  task automatic wr(input logic [7:0] c, d, input logic pp, pk,
                    output logic [2:0] res);
    @(negedge clock_in);
    {cmd_valid_out, cmd_code_out, cmd_data_out} = {1'b1, c, d};
    {pec_present_out, pec_ok_out} = {pp, pk};
    // The answer is a one-cycle pulse, so it is taken before it drops.
    @(negedge clock_in);
    res = {fault_in, reject_in, accept_in};
    {cmd_valid_out, cmd_code_out, cmd_data_out} = {1'b0, ~c, ~d};
  endtask

  // One register read, answered a cycle after it is taken.
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(negedge clock_in);
    {rd_req_out, rd_code_out} = {1'b1, c};
    @(negedge clock_in);
    {rd_req_out, rd_code_out} = {1'b0, ~c};
    @(negedge clock_in);
    d = rd_data_in;
  endtask

  // One address probe.
  task automatic probe(input logic [6:0] a, output logic h);
    @(negedge clock_in);
    {addr_valid_out, addr_out} = {1'b1, a};
    @(negedge clock_in);
    h = hit_in;
    {addr_valid_out, addr_out} = {1'b0, ~a};
  endtask
endmodule // bus_host

// ==== pmbus_write_guard_addressing_bench.sv ====
// Self-checking bench for the write guard, addressing and config bytes.
`timescale 1ns/1ps
module pmbus_write_guard_addressing_bench;
  logic       clock_in, reset_n_in, cv, pp, pk, accept, reject, fault;
  logic       rq, av, hit, fast, rdone, wp, address_select_pin, aopen, stretch, clrf;
  logic [7:0] cc, cd, rc, rdat, drove, seen, v, dt;
  logic [6:0] ad;
  logic [1:0] run, offc, onc, busy, runlow, foff, onperm, retry;
  logic [2:0] r;
  logic       sync, hit_q;
  logic [1:0] chenb;
  int         mismatches, checks_done;
  logic [7:0] rst_c [7] = '{8'hd0, 8'hd1, 8'h10, 8'he6, 8'hd8, 8'hfa, 8'h55};
  logic [7:0] rst_v [7] = '{8'h1f, 8'h09, 8'h00, 8'h4f, 8'h80, 8'h80, 8'hff};
  logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h15,
                             8'h21, 8'h78, 8'hbd, 8'he3, 8'hd0};
  logic [7:0] lk_v [4] = '{8'h80, 8'h40, 8'h20, 8'h00};

  // Short off timer keeps the run brief.
  wguard #(.MIN_OFF_CYCLES(20)) uut (
    .clock_in(clock_in), .reset_n_in(reset_n_in),
    .cmd_valid_in(cv), .cmd_code_in(cc), .cmd_data_in(cd),
    .cmd_pec_present_in(pp), .cmd_pec_ok_in(pk),
    .cmd_accept_out(accept), .cmd_reject_out(reject),
    .rd_req_in(rq), .rd_code_in(rc), .rd_valid_out(), .rd_data_out(rdat),
    .addr_valid_in(av), .addr_in(ad), .bus_fast_in(fast),
    .addr_hit_out(hit), .addr_global_out(), .addr_chan_out(),
    .clock_stretch_out(stretch), .rail_rd_done_in(rdone),
    .rail_drove_in(drove), .rail_seen_in(seen),
    .write_protect_pin_in(wp), .address_select_pin_in(address_select_pin),
    .address_select_open_in(aopen), .resistor_config_in(7'h00),
    .run_pin_in(run), .shared_sync_clock_in(sync), .gpio_low_in(2'b00),
    .off_cmd_in(offc), .on_cmd_in(onc), .turn_off_busy_in(busy),
    .below_decay_in(2'b00), .alert_chan_in(2'b00),
    .communication_fault_out(fault), .clear_faults_out(clrf),
    .run_low_pulse_out(runlow), .force_off_out(foff),
    .on_permit_out(onperm), .chan_enable_out(chenb), .retry_permit_out(retry),
    .gpio_alert_out(), .ara_address_out());

  bus_host host (
    .clock_in(clock_in), .cmd_valid_out(cv), .cmd_code_out(cc),
    .cmd_data_out(cd), .pec_present_out(pp), .pec_ok_out(pk),
    .accept_in(accept), .reject_in(reject), .fault_in(fault),
    .rd_req_out(rq), .rd_code_out(rc), .rd_data_in(rdat),
    .addr_valid_out(av), .addr_out(ad), .hit_in(hit));

  // Clock at 25 MHz.
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Counts every compare and reports a mismatch at once.
  task automatic chk(input logic [7:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic w(input logic [7:0] c, d, input logic [2:0] e);
    host.wr(c, d, 1'b0, 1'b0, r);
    chk({5'h00, r}, {5'h00, e});
  endtask

  task automatic rdc(input logic [7:0] c, e);
    host.rd(c, v);
    chk(v, e);
  endtask

  task automatic pr(input logic [6:0] a, input logic e);
    host.probe(a, hit_q);
    chk({7'h00, hit_q}, {7'h00, e});
  endtask

  // Channel command pulses; outputs sampled once registered.
  task automatic pulse(input logic [1:0] off, on);
    @(negedge clock_in);
    {offc, onc} = {off, on};
    @(negedge clock_in);
    {offc, onc} = 4'h0;
  endtask

  // Expected acceptance: intersection of lock level and protect pin sets.
  function automatic logic ok(input logic [7:0] lk, c, input logic pin);
    logic top, mid, low, pn;
    top = c inside {8'h10, 8'h00, 8'hbd, 8'h15};
    mid = top || (c inside {8'he3, 8'h01, 8'h03, 8'h78});
    low = mid || (c inside {8'h02, 8'h21});
    pn = c inside {8'h00, 8'h01, 8'he3, 8'hbd, 8'h03, 8'h78};
    ok = (lk[7] ? top : lk[6] ? mid : lk[5] ? low : 1'b1) && (!pin || pn);
  endfunction

  // Watchdog well past the expected run of under 1,500 cycles.
  initial
  begin
    #200000;
    mismatches++;
    results;
  end

  // Main sequence.
  initial
  begin
    reset_n_in = 1'b0;
    {fast, rdone, wp, address_select_pin, run, offc, onc, busy} = 12'h000;
    {aopen, drove, seen} = {1'b1, 16'h0000};
    sync = 1'b1;
    {mismatches, checks_done} = {32'd0, 32'd0};
    wt(4);
    reset_n_in = 1'b1;
    wt(3);
    foreach (rst_c[i])
      rdc(rst_c[i], rst_v[i]);
    $display("test reset values done");
    foreach (lk_v[i])
      for (int p = 0; p < 2; p++)
      begin
        wp = 1'b0;
        wt(3);
        w(8'h10, lk_v[i], 3'b001);
        wp = p[0];
        wt(3);
        foreach (codes[j])
        begin
          // Page stays on channel 0 so later paged writes land.
          dt = codes[j] == 8'h10 ? lk_v[i] :
               codes[j] == 8'h00 ? 8'h00 : 8'h1f;
          w(codes[j], dt, ok(lk_v[i], codes[j], wp) ? 3'b001 : 3'b010);
        end
      end
    wp = 1'b0;
    wt(3);
    w(8'h10, 8'h80, 3'b001);
    w(8'hd0, 8'h00, 3'b010);
    rdc(8'hd0, 8'h1f);
    w(8'h10, 8'h00, 3'b001);
    $display("test write lock done");
    fast = 1'b1;
    wt(1);
    chk(stretch, 1'b0);
    w(8'hd1, 8'h0f, 3'b001);
    chk(stretch, 1'b1);
    fast = 1'b0;
    wt(1);
    chk(stretch, 1'b0);
    w(8'h01, 8'h80, 3'b110);
    host.wr(8'h01, 8'h80, 1'b1, 1'b0, r);
    chk(r, 3'b110);
    host.wr(8'hd1, 8'h49, 1'b1, 1'b1, r);
    chk(r, 3'b001);
    $display("test check byte done");
    pr(7'h4f, 1'b1);
    pr(7'h5a, 1'b1);
    pr(7'h33, 1'b0);
    w(8'he6, 8'h80, 3'b001);
    pr(7'h4f, 1'b0);
    pr(7'h5b, 1'b1);
    w(8'hfa, 8'h40, 3'b001);
    pr(7'h40, 1'b1);
    w(8'hfa, 8'h80, 3'b001);
    pr(7'h40, 1'b0);
    w(8'hd8, 8'h30, 3'b001);
    {aopen, address_select_pin} = 2'b01;
    wt(3);
    pr(7'h31, 1'b1);
    pr(7'h30, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clock_in);
      {rdone, drove, seen} = {1'b1, 8'h5a, 8'h5a ^ 8'(i)};
      wt(1);
      chk(fault, i[0]);
      rdone = 1'b0;
    end
    $display("test addressing done");
    pulse(2'b01, 2'b00);
    chk(runlow, 2'b00);
    w(8'hd0, 8'h0e, 3'b001);
    chk(retry, 2'b10);
    pulse(2'b01, 2'b00);
    chk(runlow, 2'b01);
    busy = 2'b01;
    pulse(2'b00, 2'b01);
    chk(foff, 2'b01);
    wt(18);
    chk(onperm, 2'b10);
    wt(6);
    chk(onperm, 2'b11);
    sync = 1'b0;
    wt(3);
    chk(chenb, 2'b00);
    sync = 1'b1;
    wt(3);
    chk(chenb, 2'b11);
    v = 8'h00;
    run = 2'b10;
    repeat (6)
    begin
      @(negedge clock_in);
      v[0] = v[0] | clrf;
    end
    chk(v[0], 1'b1);
    $display("test channel config done");
    results;
  end
endmodule // pmbus_write_guard_addressing_bench
